// ### core/serial_irq_pkg.sv
// Package with register map, field positions, reset values and timing constants for the serial block.
package serial_irq_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [11:0] ctrl_offset   = 12'h000;
    localparam logic [11:0] status_offset = 12'h004;
    localparam logic [11:0] txbuf_offset  = 12'h008;
    localparam logic [11:0] rxbuf_offset  = 12'h00C;
    localparam logic [11:0] baud_offset   = 12'h010;
    localparam logic [11:0] port_offset   = 12'h014;

    // ****************************************
    // Control fields
    // ****************************************
    localparam int ctrl_tx_irq_enable_bit     = 7;
    localparam int ctrl_rx_irq_enable_bit     = 6;
    localparam int ctrl_tx_enable_bit         = 5;
    localparam int ctrl_rx_enable_bit         = 4;
    localparam int ctrl_tx_end_irq_enable_bit = 2;
    localparam int ctrl_sync_mode_bit         = 0;

    // ****************************************
    // Status fields
    // ****************************************
    localparam int st_tx_empty_bit = 7;
    localparam int st_rx_full_bit  = 6;
    localparam int st_overrun_bit  = 5;
    localparam int st_framing_bit  = 4;
    localparam int st_parity_bit   = 3;
    localparam int st_tx_end_bit   = 2;

    // ****************************************
    // Port control fields
    // ****************************************
    localparam int port_level_bit     = 0;
    localparam int port_direction_bit = 1;

    // ****************************************
    // Reset values and timing
    // ****************************************
    localparam logic [7:0]  ctrl_reset     = 8'h00;
    localparam logic [15:0] baud_reset     = 16'h0000;
    localparam logic [3:0]  oversample     = 4'hF;
    localparam logic [3:0]  sample_point   = 4'h7;
    localparam logic [3:0]  data_bits      = 4'h8;
    localparam logic [3:0]  sync_half_bits = 4'h0;

    typedef enum logic [1:0] {
        rx_idle,
        rx_start,
        rx_data,
        rx_stop
    } rx_state_t;

    typedef enum logic [1:0] {
        tx_idle,
        tx_start,
        tx_data,
        tx_stop
    } tx_state_t;

endpackage

// ### core/serial_irq_flags.sv
// Serial interface with status flags, interrupt requests and APB register access.
module serial_irq_flags
    import serial_irq_pkg::*;
#(
    parameter int parity_enable = 1
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        serial_in_pin,
    output logic             serial_out_pin,
    output logic             serial_out_oe,
    output logic             rx_full_irq,
    output logic             tx_empty_irq,
    output logic             tx_end_irq,
    output logic             rx_error_irq
);

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0]  serial_control_reg;
    logic [15:0] baud_reg;
    logic [1:0]  port_reg;
    logic [7:0]  tx_buffer_reg;
    logic [7:0]  rx_buffer_reg;
    logic        tx_buffer_empty_flag_reg;
    logic        tx_end_flag_reg;
    logic        rx_buffer_full_flag_reg;
    logic        overrun_flag_reg;
    logic        framing_flag_reg;
    logic        parity_flag_reg;
    logic        in_meta_reg;
    logic        in_sync_reg;
    logic        in_prev_reg;

    logic tx_irq_enable;
    logic rx_irq_enable;
    logic tx_end_irq_enable;
    logic tx_enable;
    logic rx_enable;
    logic sync_mode;
    logic any_error;

    assign tx_irq_enable     = serial_control_reg[ctrl_tx_irq_enable_bit];
    assign rx_irq_enable     = serial_control_reg[ctrl_rx_irq_enable_bit];
    assign tx_end_irq_enable = serial_control_reg[ctrl_tx_end_irq_enable_bit];
    assign tx_enable         = serial_control_reg[ctrl_tx_enable_bit];
    assign rx_enable         = serial_control_reg[ctrl_rx_enable_bit];
    assign sync_mode         = serial_control_reg[ctrl_sync_mode_bit];
    assign any_error         = overrun_flag_reg | framing_flag_reg | parity_flag_reg;

    // ****************************************
    // APB decode
    // ****************************************
    logic wr;
    logic rd;
    logic hit;

    assign wr     = psel & penable & pready & pwrite;
    assign rd     = psel & penable & pready & ~pwrite;
    assign hit    = (paddr == ctrl_offset) || (paddr == status_offset) ||
                    (paddr == txbuf_offset) || (paddr == rxbuf_offset) ||
                    (paddr == baud_offset) || (paddr == port_offset);

    logic write_ctrl;
    logic write_status;
    logic write_txbuf;
    logic read_rxbuf;

    assign write_ctrl   = wr && (paddr == ctrl_offset);
    assign write_status = wr && (paddr == status_offset);
    assign write_txbuf  = wr && (paddr == txbuf_offset);
    assign read_rxbuf   = rd && (paddr == rxbuf_offset);

    // Ready is raised in the access phase, giving one wait state.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && penable && !pready && !pwrite) begin
            if (paddr == ctrl_offset) begin
                prdata <= {24'h00_0000, serial_control_reg};
            end else if (paddr == status_offset) begin
                prdata <= {24'h00_0000, tx_buffer_empty_flag_reg, rx_buffer_full_flag_reg,
                           overrun_flag_reg, framing_flag_reg, parity_flag_reg,
                           tx_end_flag_reg, 2'b00};
            end else if (paddr == txbuf_offset) begin
                prdata <= {24'h00_0000, tx_buffer_reg};
            end else if (paddr == rxbuf_offset) begin
                prdata <= {24'h00_0000, rx_buffer_reg};
            end else if (paddr == baud_offset) begin
                prdata <= {16'h0000, baud_reg};
            end else if (paddr == port_offset) begin
                prdata <= {30'h0000_0000, port_reg};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            serial_control_reg <= ctrl_reset;
            baud_reg           <= baud_reset;
            port_reg           <= 2'b00;
            tx_buffer_reg      <= 8'h00;
        end else if (write_ctrl) begin
            serial_control_reg <= pwdata[7:0];
        end else if (wr && paddr == baud_offset) begin
            baud_reg <= pwdata[15:0];
        end else if (wr && paddr == port_offset) begin
            port_reg <= pwdata[1:0];
        end else if (write_txbuf) begin
            tx_buffer_reg <= pwdata[7:0];
        end
    end

    // ****************************************
    // Bit-rate tick generators
    // ****************************************
    logic [15:0] rx_div_reg;
    logic [15:0] tx_div_reg;
    logic        rx_tick;
    logic        tx_tick;
    logic [3:0]  tx_phase_reg;

    assign rx_tick = (rx_div_reg == baud_reg);
    assign tx_tick = (tx_div_reg == baud_reg) && (tx_phase_reg == oversample);

    // The receive basic clock runs at 16 times the bit rate.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_div_reg <= 16'h0000;
        end else if (rx_tick) begin
            rx_div_reg <= 16'h0000;
        end else begin
            rx_div_reg <= rx_div_reg + 16'h0001;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_div_reg   <= 16'h0000;
            tx_phase_reg <= 4'h0;
        end else if (tx_div_reg == baud_reg) begin
            tx_div_reg   <= 16'h0000;
            tx_phase_reg <= tx_phase_reg + 4'h1;
        end else begin
            tx_div_reg <= tx_div_reg + 16'h0001;
        end
    end

    // ****************************************
    // Transmitter
    // ****************************************
    tx_state_t  tx_state_reg;
    logic [7:0] tx_shift_register;
    logic [3:0] tx_count_reg;
    logic       tx_line_reg;
    logic       tx_load;

    // A load takes a waiting byte when idle or after a stop bit.
    assign tx_load = tx_enable && !tx_buffer_empty_flag_reg && tx_tick &&
                     (tx_state_reg == tx_idle || tx_state_reg == tx_stop) &&
                     !(sync_mode && any_error);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_reg      <= tx_idle;
            tx_shift_register <= 8'h00;
            tx_count_reg      <= 4'h0;
            tx_line_reg       <= 1'b1;
        end else if (!tx_enable) begin
            tx_state_reg <= tx_idle;
            tx_line_reg  <= 1'b1;
            tx_count_reg <= 4'h0;
        end else if (tx_load) begin
            tx_shift_register <= tx_buffer_reg;
            tx_state_reg      <= tx_start;
            tx_line_reg       <= 1'b0;
        end else if (tx_tick) begin
            case (tx_state_reg)
                tx_start: begin
                    tx_line_reg       <= tx_shift_register[0];
                    tx_shift_register <= {1'b1, tx_shift_register[7:1]};
                    tx_count_reg      <= 4'h1;
                    tx_state_reg      <= tx_data;
                end
                tx_data: begin
                    if (tx_count_reg == data_bits) begin
                        tx_line_reg  <= 1'b1;
                        tx_state_reg <= tx_stop;
                    end else begin
                        tx_line_reg       <= tx_shift_register[0];
                        tx_shift_register <= {1'b1, tx_shift_register[7:1]};
                        tx_count_reg      <= tx_count_reg + 4'h1;
                    end
                end
                tx_stop: begin
                    tx_state_reg <= tx_idle;
                end
                default: begin
                    tx_line_reg <= 1'b1;
                end
            endcase
        end
    end

    // A write clears the empty flag, a load sets it; the set wins.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_buffer_empty_flag_reg <= 1'b1;
        end else if (tx_load) begin
            tx_buffer_empty_flag_reg <= 1'b1;
        end else if (write_txbuf) begin
            tx_buffer_empty_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_end_flag_reg <= 1'b1;
        end else if (tx_state_reg == tx_stop && tx_tick && !tx_load) begin
            tx_end_flag_reg <= 1'b1;
        end else if (tx_load) begin
            tx_end_flag_reg <= 1'b0;
        end
    end

    // With transmit disabled the pin follows the port level and direction.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            serial_out_pin <= 1'b1;
            serial_out_oe  <= 1'b0;
        end else if (!tx_enable) begin
            serial_out_pin <= port_reg[port_level_bit];
            serial_out_oe  <= port_reg[port_direction_bit];
        end else begin
            serial_out_pin <= tx_line_reg;
            serial_out_oe  <= 1'b1;
        end
    end

    // ****************************************
    // Receiver
    // ****************************************
    rx_state_t  rx_state_reg;
    logic [7:0] rx_shift_register;
    logic [3:0] rx_phase_reg;
    logic [3:0] rx_count_reg;
    logic       rx_parity_reg;
    logic       rx_done;
    logic       rx_stop_bad;
    logic       sample;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            in_meta_reg <= 1'b1;
            in_sync_reg <= 1'b1;
            in_prev_reg <= 1'b1;
        end else begin
            in_meta_reg <= serial_in_pin;
            in_sync_reg <= in_meta_reg;
            in_prev_reg <= rx_tick ? in_sync_reg : in_prev_reg;
        end
    end

    assign sample = rx_tick && (rx_phase_reg == sample_point);
    assign rx_done     = sample && rx_state_reg == rx_stop;
    assign rx_stop_bad = !in_sync_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_reg      <= rx_idle;
            rx_shift_register <= 8'h00;
            rx_phase_reg      <= 4'h0;
            rx_count_reg      <= 4'h0;
            rx_parity_reg     <= 1'b0;
        end else if (!rx_enable) begin
            rx_state_reg <= rx_idle;
        end else if (rx_tick) begin
            rx_phase_reg <= rx_phase_reg + 4'h1;
            case (rx_state_reg)
                rx_idle: begin
                    if (in_prev_reg && !in_sync_reg) begin
                        rx_state_reg <= rx_start;
                        rx_phase_reg <= 4'h1;
                    end
                end
                rx_start: begin
                    if (rx_phase_reg == sample_point) begin
                        rx_state_reg  <= in_sync_reg ? rx_idle : rx_data;
                        rx_count_reg  <= 4'h0;
                        rx_parity_reg <= 1'b0;
                    end
                end
                rx_data: begin
                    if (rx_phase_reg == sample_point) begin
                        rx_shift_register <= {in_sync_reg, rx_shift_register[7:1]};
                        rx_parity_reg     <= rx_parity_reg ^ in_sync_reg;
                        rx_count_reg      <= rx_count_reg + 4'h1;
                        if (rx_count_reg == data_bits - 4'h1) begin
                            rx_state_reg <= rx_stop;
                        end
                    end
                end
                default: begin
                    if (rx_phase_reg == sample_point) begin
                        rx_state_reg <= rx_idle;
                    end
                end
            endcase
        end
    end

    // A break gives all zeros: framing fails, but the parity of zero data bits is 0, so the parity check never flags.
    logic frame_ok;

    assign frame_ok = rx_done && !rx_buffer_full_flag_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_buffer_reg <= 8'h00;
        end else if (frame_ok) begin
            rx_buffer_reg <= rx_shift_register;
        end
    end

    // Frame end without a framing or parity error sets the full flag; a read clears it; the set wins.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_buffer_full_flag_reg <= 1'b0;
        end else if (frame_ok && !rx_stop_bad && !(parity_enable != 0 && rx_parity_reg)) begin
            rx_buffer_full_flag_reg <= 1'b1;
        end else if (read_rxbuf) begin
            rx_buffer_full_flag_reg <= 1'b0;
        end
    end

    // Error flags clear only by writing 0 to their status bits.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            overrun_flag_reg <= 1'b0;
            framing_flag_reg <= 1'b0;
            parity_flag_reg  <= 1'b0;
        end else begin
            if (rx_done && rx_buffer_full_flag_reg) begin
                overrun_flag_reg <= 1'b1;
            end else if (write_status && !pwdata[st_overrun_bit]) begin
                overrun_flag_reg <= 1'b0;
            end
            if (rx_done && rx_stop_bad) begin
                framing_flag_reg <= 1'b1;
            end else if (write_status && !pwdata[st_framing_bit]) begin
                framing_flag_reg <= 1'b0;
            end
            if (rx_done && parity_enable != 0 && rx_parity_reg) begin
                parity_flag_reg <= 1'b1;
            end else if (write_status && !pwdata[st_parity_bit]) begin
                parity_flag_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // Interrupt requests
    // ****************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_full_irq  <= 1'b0;
            tx_empty_irq <= 1'b0;
            tx_end_irq   <= 1'b0;
            rx_error_irq <= 1'b0;
        end else begin
            rx_full_irq  <= rx_buffer_full_flag_reg & rx_irq_enable;
            tx_empty_irq <= tx_buffer_empty_flag_reg & tx_irq_enable;
            tx_end_irq   <= tx_end_flag_reg & tx_end_irq_enable;
            rx_error_irq <= any_error & rx_irq_enable;
        end
    end

endmodule

// ### sim/line_sender.sv
// Remote serial transmitter that drives frames onto the receive line.
module line_sender (
    input  wire logic       clock,
    input  wire logic       go,
    input  wire logic [7:0] data,
    input  wire logic       stop_val,
    output logic            line,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [9:0] frame;

    initial begin
        line = 1'b1;
        busy = 1'b0;
    end

    // A stop value of 0 with zero data makes a break frame.
    always @(posedge clock) begin
        if (go && !busy) begin
            busy <= 1'b1;
            frame = {stop_val, data, 1'b0};
            for (int i = 0; i < 10; i++) begin
                line <= frame[i];
                repeat (16) @(posedge clock);
            end
            line <= 1'b1;
            busy <= 1'b0;
        end
    end
endmodule

// ### sim/serial_irq_flags_assertions.sv
// Checker with concurrent assertions on the serial block's ports.
module serial_irq_flags_checker (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        serial_out_pin,
    input wire logic        serial_out_oe,
    input wire logic        rx_full_irq,
    input wire logic        tx_empty_irq,
    input wire logic        tx_end_irq,
    input wire logic        rx_error_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ctrl_sh;
    logic [1:0] port_sh;
    logic       port_set;
    logic       tx_wr;
    logic       wr;

    assign wr = psel && penable && pready && pwrite;

    // Shadows of the host writes, used to judge gating and port control.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_sh <= 8'h00;
            port_sh <= 2'b00;
            port_set <= 1'b0;
            tx_wr <= 1'b0;
        end else if (wr) begin
            if (paddr == 12'h000) ctrl_sh <= pwdata[7:0];
            if (paddr == 12'h014) port_sh <= pwdata[1:0];
            if (paddr == 12'h014) port_set <= 1'b1;
            if (paddr == 12'h008) tx_wr <= 1'b1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    chk_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after access phase");
    chk_ready_pulse: assert property (pready |-> (psel && penable) ##1 !pready)
        else $error("pready outside access or too long");
    chk_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("refused read returned data");
    chk_tx_empty_gate: assert property (tx_empty_irq |-> $past(ctrl_sh[7]))
        else $error("transmit empty request while disabled");
    chk_tx_end_gate: assert property (tx_end_irq |-> $past(ctrl_sh[2]))
        else $error("transmit end request while disabled");
    chk_rx_full_gate: assert property (rx_full_irq |-> $past(ctrl_sh[6]))
        else $error("receive full request while disabled");
    chk_rx_error_gate: assert property (rx_error_irq |-> $past(ctrl_sh[6]))
        else $error("receive error request while disabled");
    chk_reset_empty: assert property ($rose(ctrl_sh[7]) && !tx_wr |-> ##[1:2] tx_empty_irq)
        else $error("no transmit empty request after reset");
    chk_reset_end: assert property ($rose(ctrl_sh[2]) && !tx_wr |-> ##[1:2] tx_end_irq)
        else $error("no transmit end request after reset");
    chk_port_pin: assert property (port_set && $past(port_set) && !$past(ctrl_sh[5])
        |-> serial_out_pin == $past(port_sh[0]) && serial_out_oe == $past(port_sh[1]))
        else $error("transmit pin not under port control");

    cover property (rx_error_irq);
    cover property (pready && pslverr);
    cover property (rx_full_irq && tx_empty_irq);
endmodule

bind serial_irq_flags serial_irq_flags_checker chk_i (.clock(clock), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_out_pin(serial_out_pin),
    .serial_out_oe(serial_out_oe), .rx_full_irq(rx_full_irq), .tx_empty_irq(tx_empty_irq),
    .tx_end_irq(tx_end_irq), .rx_error_irq(rx_error_irq));

// ### sim/serial_irq_and_status_flags_bench.sv
// Self-checking bench for the serial status flags and interrupt requests.
module serial_irq_and_status_flags_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import serial_irq_pkg::*;

    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        go = 1'b0;
    logic        stop = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] seed = 32'h0000_002C;
    logic [31:0] prdata, rdat;
    logic [7:0]  sdata = 8'h00;
    logic [7:0]  b, sb;
    logic        pready, pslverr, err, line, busy, out_pin, out_oe;
    logic        irq_rf, irq_te, irq_tn, irq_re;
    int          mismatches = 0;
    int          tests_run = 0;

    always #5 clock = ~clock;

    serial_irq_flags #(.parity_enable(0)) DUT (.clock(clock), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_in_pin(line), .serial_out_pin(out_pin),
        .serial_out_oe(out_oe), .rx_full_irq(irq_rf), .tx_empty_irq(irq_te),
        .tx_end_irq(irq_tn), .rx_error_irq(irq_re));

    line_sender LS (.clock(clock), .go(go), .data(sdata), .stop_val(stop), .line(line),
        .busy(busy));

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    function automatic logic [31:0] stat(input logic f, input logic o, input logic m);
        return {24'h0, 1'b1, f, o, m, 4'h4};
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) mismatches++;
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(n, e, rdat);
    endtask

    // Waits for a start bit on the transmit pin and samples eight data bits mid-bit.
    task automatic catch(output logic [7:0] d);
        int n = 0;
        repeat (2) @(posedge clock);
        while (out_pin !== 1'b0 && n < 400) begin
            @(posedge clock);
            n++;
        end
        repeat (8) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge clock);
            d[i] = out_pin;
        end
    endtask

    task automatic send(input logic [7:0] d, input logic s);
        int n;
        @(posedge clock);
        sdata <= d;
        stop <= s;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        n = 0;
        while ((busy !== 1'b0 || n < 2) && n < 400) begin
            @(posedge clock);
            n++;
        end
        repeat (24) @(posedge clock);
    endtask

    task automatic end_sim();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        end_sim();
    end

    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        rd("status", status_offset, stat(0, 0, 0));
        apb(1'b1, ctrl_offset, 32'h0000_0084);
        repeat (3) @(posedge clock);
        chk("tx irqs", 32'h0000_0003, {irq_te, irq_tn});
        apb(1'b1, port_offset, 32'h0000_0002);
        repeat (3) @(posedge clock);
        chk("port pin", 32'h0000_0002, {out_oe, out_pin});
        apb(1'b1, ctrl_offset, 32'h0000_0070);
        apb(1'b1, txbuf_offset, {24'h0, rnd()});
        apb(1'b1, ctrl_offset, 32'h0000_00F4);
        repeat (20) @(posedge clock);
        rd("tx loaded", status_offset, 32'h0000_0080);
        apb(1'b1, txbuf_offset, {24'h0, rnd()});
        apb(1'b0, status_offset, 32'h0000_0000);
        chk("tx waiting", 32'h0000_0000, rdat & 32'h0000_0080);
        repeat (400) @(posedge clock);
        rd("tx done", status_offset, stat(0, 0, 0));
        for (int i = 0; i < 3; i++) begin
            b = rnd();
            send(b, 1'b1);
            rd("rx status", status_offset, stat(1, 0, 0));
            chk("rx irq", 32'h0000_0001, irq_rf);
            rd("rx data", rxbuf_offset, {24'h0, b});
            rd("rx clear", status_offset, stat(0, 0, 0));
        end
        b = rnd();
        send(b, 1'b1);
        send(~b, 1'b1);
        rd("overrun", status_offset, stat(1, 1, 0));
        chk("error irq", 32'h0000_0001, irq_re);
        rd("kept data", rxbuf_offset, {24'h0, b});
        rd("late read", status_offset, stat(0, 1, 0));
        apb(1'b1, status_offset, 32'h0000_0000);
        b = rnd();
        send(b, 1'b0);
        rd("framing", status_offset, stat(0, 0, 1));
        rd("framed data", rxbuf_offset, {24'h0, b});
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, status_offset, 32'h0000_0000);
            send(8'h00, 1'b0);
            rd("break", status_offset, stat(0, 0, 1));
        end
        apb(1'b1, ctrl_offset, 32'h0000_00E5);
        apb(1'b1, txbuf_offset, {24'h0, rnd()});
        repeat (50) @(posedge clock);
        apb(1'b0, status_offset, 32'h0000_0000);
        chk("held tx", 32'h0000_0010, rdat & 32'h0000_00B8);
        apb(1'b1, status_offset, 32'h0000_0000);
        repeat (400) @(posedge clock);
        rd("tx resumed", status_offset, stat(0, 0, 0));
        apb(1'b1, ctrl_offset, 32'h0000_00D4);
        apb(1'b1, txbuf_offset, {24'h0, rnd()});
        b = rnd();
        apb(1'b1, txbuf_offset, {24'h0, b});
        apb(1'b1, ctrl_offset, 32'h0000_00F4);
        catch(sb);
        chk("tx data", {24'h0, b}, {24'h0, sb});
        apb(1'b1, txbuf_offset, {24'h0, rnd()});
        repeat (30) @(posedge clock);
        apb(1'b1, ctrl_offset, 32'h0000_0000);
        repeat (3) @(posedge clock);
        chk("abort pin", 32'h0000_0002, {out_oe, out_pin});
        apb(1'b0, 12'h018, 32'h0000_0000);
        chk("unmapped data", 32'h0000_0000, rdat);
        chk("unmapped err", 32'h0000_0001, err);
        end_sim();
    end
endmodule
